// ### pss_engine_model.sv
// pss_engine_model: stand-in for the protocol engine and its master
// assumes: bench commands port state, offset and phase steps by level
`timescale 1ns/1ps
module pss_engine_model #(
  parameter logic [63:0] MASTER_ID = 64'h0000_0011_0000_0022
) (
  input logic clk_in,
  input logic rst_in,
  input logic sync_on_in,
  input logic [3:0] state_in,
  input logic [31:0] offset_in,
  input logic step_req_in,
  output logic [31:0] offset_out,
  output logic [63:0] parent_id_out,
  output logic [3:0] port_state_out,
  output logic [31:0] freq_adj_out,
  output logic step_valid_out,
  output logic [31:0] step_ns_out
);
  logic step_seen;
  // a master only answers once sync runs, so ids stay zero until then
  always_ff @(posedge clk_in) begin
    offset_out <= offset_in;
    parent_id_out <= sync_on_in ? MASTER_ID : 64'h0;
    port_state_out <= sync_on_in ? state_in : 4'h3;
  end
  // quarter ns per cycle of rate trim, one phase step per request
  always_ff @(posedge clk_in) begin
    freq_adj_out <= 32'h4000_0000;
    step_ns_out <= 32'h0000_03E8;
    step_seen <= rst_in ? 1'b0 : step_req_in;
    step_valid_out <= !rst_in && step_req_in && !step_seen;
  end
endmodule

// ### pss_local_clock.sv
// pss_local_clock: 64-bit nanosecond time base with phase and rate trim
// assumes: trim inputs come from the protocol engine, sync to clk
`timescale 1ns/1ps
module pss_local_clock #(
  parameter int NS_PER_CYCLE = pss_pkg::CLK_PERIOD_NS
) (
  input logic clk_in,
  input logic rst_in,
  input logic adj_en_in,
  input logic step_valid_in,
  input logic [31:0] step_ns_in,
  input logic [31:0] freq_adj_in,
  output logic [63:0] now_out
);
  if (NS_PER_CYCLE < 1) begin : g_bad
    $error("pss_local_clock: NS_PER_CYCLE must be positive");
  end

  // 64 bits of ns plus 32 bits of fraction so rate trim is sub-ns
  logic [95:0] t;
  logic [95:0] inc;
  logic [95:0] step;

  always_comb begin
    inc = {64'(NS_PER_CYCLE), 32'h0};
    step = 96'h0;
    // [R8] rate and value trim
    if (adj_en_in) begin
      inc = inc + {{64{freq_adj_in[31]}}, freq_adj_in};
      if (step_valid_in) begin
        step = {{32{step_ns_in[31]}}, step_ns_in, 32'h0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      t <= 96'h0;
    end else begin
      t <= t + inc + step;
    end
  end

  assign now_out = t[95:32];
endmodule

// ### pss_period_div.sv
// pss_period_div: restoring divider, one quotient bit per clock
// assumes: start is a one-cycle pulse; a new start restarts it
`timescale 1ns/1ps
module pss_period_div #(
  parameter int W = 32
) (
  input logic clk_in,
  input logic rst_in,
  input logic start_in,
  input logic [W-1:0] dividend_in,
  input logic [W-1:0] divisor_in,
  output logic [W-1:0] quot_out,
  output logic done_out,
  output logic busy_out
);
  if (W < 2 || W > 63) begin : g_bad
    $error("pss_period_div: W out of range");
  end

  logic [W:0] rem;
  logic [W:0] shifted;
  logic [W-1:0] dsr;
  logic [6:0] cnt;

  assign shifted = {rem[W-1:0], quot_out[W-1]};

  // [R19] period by long division
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rem <= '0;
      quot_out <= '0;
      dsr <= '0;
      cnt <= 7'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        rem <= '0;
        quot_out <= dividend_in;
        dsr <= divisor_in;
        cnt <= 7'(W);
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (shifted >= {1'b0, dsr}) begin
          rem <= shifted - {1'b0, dsr};
          quot_out <= {quot_out[W-2:0], 1'b1};
        end else begin
          rem <= shifted;
          quot_out <= {quot_out[W-2:0], 1'b0};
        end
        cnt <= cnt - 7'h01;
        if (cnt == 7'h01) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end
endmodule

// ### pss_pkg.sv
// pss_pkg: constants, register map and types for the ptp status block
// assumes: 40 MHz system clock; offsets are byte addresses on the port
package pss_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // live port state refresh interval
  localparam int REFRESH_NS = 1000;
  localparam int REFRESH_CYC_I =
    (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] REFRESH_CYC = 8'(REFRESH_CYC_I);
  localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
  localparam int DIV_CYC = 33;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_OFFSET = 8'h08;
  localparam logic [7:0] A_OWN_LO = 8'h0C;
  localparam logic [7:0] A_OWN_HI = 8'h10;
  localparam logic [7:0] A_MST_LO = 8'h14;
  localparam logic [7:0] A_MST_HI = 8'h18;
  localparam logic [7:0] A_STATE_SNAP = 8'h1C;
  localparam logic [7:0] A_STATE_LIVE = 8'h20;
  localparam logic [7:0] A_TS_LO = 8'h24;
  localparam logic [7:0] A_TS_HI = 8'h28;
  localparam logic [7:0] A_START_LO = 8'h2C;
  localparam logic [7:0] A_START_HI = 8'h30;
  localparam logic [7:0] A_RATE = 8'h34;
  localparam logic [7:0] A_STATUS = 8'h38;

  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_SRC_LO = 1;
  localparam int CTRL_SRC_HI = 2;
  localparam logic [1:0] SRC_SCHED = 2'h1;
  localparam int CMD_SNAP_BIT = 0;
  localparam int CMD_TS_BIT = 1;
  localparam int CMD_UPD_BIT = 2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] START_RST = 32'h0000_0000;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    PS_INITIALIZING = 4'h1,
    PS_FAULTY = 4'h2,
    PS_DISABLED = 4'h3,
    PS_LISTENING = 4'h4,
    PS_PRE_MASTER = 4'h5,
    PS_MASTER = 4'h6,
    PS_PASSIVE = 4'h7,
    PS_UNCALIBRATED = 4'h8,
    PS_SLAVE = 4'h9
  } pss_port_state_e;

  typedef enum logic [1:0] {
    TRG_IDLE = 2'b00,
    TRG_DIV = 2'b01,
    TRG_RUN = 2'b10
  } pss_trig_e;

  typedef struct packed {
    logic [31:0] offset;
    logic [63:0] own_id;
    logic [63:0] master_id;
    pss_port_state_e state;
  } pss_snap_s;
endpackage

// ### pss_top.sv
// pss_top: time sync status snapshot, time stamp latch, trigger timer
// assumes: protocol engine outside feeds offset, parent id, port state
// and clock trim; software uses the plain strobe register port
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// [R1] 32-bit master offset in ns readable
// [R2] 64-bit own clock identifier readable
// [R3] 64-bit current master identifier readable
// [R4] port state uses the nine standard codes
// [R5] snapshot captures four values same instant
// [R6] snapshot frozen until next snapshot command
// [R7] live state refreshed periodically, no command
// [R8] enabled: slave state, trim time and rate
// [R9] start time is two 32-bit halves
// [R10] zero or past start fires at once
// [R11] future start fires when time reaches it
// [R12] time stamp command copies local time
// [R13] triggers at programmed frames per second
// [R14] start and rate applied only on update
// [R15] timer fires only when selected as source
// [R16] software waits for settled roles, small offset
// [R17] sync disabled after reset until enabled
// [R18] surplus triggers dropped while frame busy
// [R19] period is one second over rate
module pss_top #(
  // arbitrary identity value
  parameter logic [63:0] OWN_CLOCK_ID = 64'h0000_0000_0000_0001
) (
  input logic CLK_SYS_IN,
  input logic RST_IN,
  input logic [7:0] REG_ADDR_IN,
  input logic [31:0] REG_WDATA_IN,
  input logic REG_WR_IN,
  input logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  input logic [31:0] OFFSET_IN,
  input logic [63:0] PARENT_ID_IN,
  input logic [3:0] PORT_STATE_IN,
  input logic [31:0] FREQ_ADJ_IN,
  input logic STEP_VALID_IN,
  input logic [31:0] STEP_NS_IN,
  input logic FRAME_BUSY_IN,
  output logic TIME_SYNC_ENABLE_OUT,
  output logic [3:0] LIVE_STATE_OUT,
  output logic [63:0] LOCAL_TIME_OUT,
  output logic TRIG_OUT
);
  if (pss_pkg::REFRESH_CYC_I < 1 || pss_pkg::REFRESH_CYC_I > 255)
  begin : g_bad
    $error("pss_top: refresh count does not fit");
  end

  logic [31:0] ctrl;
  logic [31:0] start_lo;
  logic [31:0] start_hi;
  logic [31:0] rate;
  logic sync_en;
  logic sched_sel;
  logic cmd_snap;
  logic cmd_ts;
  logic cmd_upd;
  pss_pkg::pss_port_state_e cur_state;
  pss_pkg::pss_port_state_e live;
  pss_pkg::pss_snap_s snap;
  logic [7:0] ref_cnt;
  logic [63:0] now;
  logic [63:0] ts_snap;
  logic [63:0] act_start;
  logic [31:0] act_rate;
  logic [31:0] period;
  logic [31:0] quot;
  logic div_done;
  logic [63:0] next_fire;
  logic [63:0] next_step;
  pss_pkg::pss_trig_e st;
  logic fire;
  logic [15:0] drop_cnt;

  assign sync_en = ctrl[pss_pkg::CTRL_SYNC_BIT];
  assign sched_sel = ctrl[pss_pkg::CTRL_SRC_HI:pss_pkg::CTRL_SRC_LO]
    == pss_pkg::SRC_SCHED;
  assign cmd_snap = REG_WR_IN && REG_ADDR_IN == pss_pkg::A_CMD
    && REG_WDATA_IN[pss_pkg::CMD_SNAP_BIT];
  assign cmd_ts = REG_WR_IN && REG_ADDR_IN == pss_pkg::A_CMD
    && REG_WDATA_IN[pss_pkg::CMD_TS_BIT];
  assign cmd_upd = REG_WR_IN && REG_ADDR_IN == pss_pkg::A_CMD
    && REG_WDATA_IN[pss_pkg::CMD_UPD_BIT];

  // [R17] enable cleared by reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ctrl <= pss_pkg::CTRL_RST;
    end else if (REG_WR_IN && REG_ADDR_IN == pss_pkg::A_CTRL) begin
      ctrl <= REG_WDATA_IN;
    end
  end

  // [R9] pending start halves and rate
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      start_lo <= pss_pkg::START_RST;
      start_hi <= pss_pkg::START_RST;
      rate <= pss_pkg::RATE_RST;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == pss_pkg::A_START_LO) begin
        start_lo <= REG_WDATA_IN;
      end
      if (REG_ADDR_IN == pss_pkg::A_START_HI) begin
        start_hi <= REG_WDATA_IN;
      end
      if (REG_ADDR_IN == pss_pkg::A_RATE) begin
        rate <= REG_WDATA_IN;
      end
    end
  end

  // [R4] engine state, forced to disabled while sync is off
  always_comb begin
    if (sync_en) begin
      cur_state = pss_pkg::pss_port_state_e'(PORT_STATE_IN);
    end else begin
      cur_state = pss_pkg::PS_DISABLED;
    end
  end

  // [R7] periodic live state copy
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ref_cnt <= 8'h00;
      live <= pss_pkg::PS_DISABLED;
    end else if (ref_cnt == 8'h00) begin
      ref_cnt <= pss_pkg::REFRESH_CYC - 8'h01;
      live <= cur_state;
    end else begin
      ref_cnt <= ref_cnt - 8'h01;
    end
  end

  // [R5] four values captured together
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      snap <= '{32'h0, 64'h0, 64'h0, pss_pkg::PS_DISABLED};
    end else if (cmd_snap) begin
      snap <= '{OFFSET_IN, OWN_CLOCK_ID, PARENT_ID_IN, cur_state};
    end
  end

  // [R8] trim only while slaved to a master
  pss_local_clock #(
    .NS_PER_CYCLE(pss_pkg::CLK_PERIOD_NS)
  ) u_clock (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .adj_en_in(cur_state == pss_pkg::PS_SLAVE),
    .step_valid_in(STEP_VALID_IN),
    .step_ns_in(STEP_NS_IN),
    .freq_adj_in(FREQ_ADJ_IN),
    .now_out(now)
  );

  // [R12] time stamp latch
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ts_snap <= 64'h0;
    end else if (cmd_ts) begin
      ts_snap <= now;
    end
  end

  // [R14] all pending values applied at once
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      act_start <= 64'h0;
      act_rate <= 32'h0;
    end else if (cmd_upd) begin
      act_start <= {start_hi, start_lo};
      act_rate <= rate;
    end
  end

  // [R19] one second over rate
  pss_period_div #(
    .W(32)
  ) u_div (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .start_in(cmd_upd),
    .dividend_in(pss_pkg::NS_PER_SEC),
    .divisor_in(rate),
    .quot_out(quot),
    .done_out(div_done),
    .busy_out()
  );

  // a new update during division simply restarts it
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      st <= pss_pkg::TRG_IDLE;
      period <= 32'h0;
    end else begin
      case (st)
        pss_pkg::TRG_IDLE: begin
          if (cmd_upd) begin
            st <= pss_pkg::TRG_DIV;
          end
        end
        pss_pkg::TRG_DIV: begin
          if (div_done && !cmd_upd) begin
            st <= pss_pkg::TRG_RUN;
            period <= quot;
          end
        end
        pss_pkg::TRG_RUN: begin
          if (cmd_upd) begin
            st <= pss_pkg::TRG_DIV;
          end
        end
        default: begin
          st <= pss_pkg::TRG_IDLE;
        end
      endcase
    end
  end

  // [R15] fires only when selected; [R13] rate zero means stopped
  assign fire = st == pss_pkg::TRG_RUN && sched_sel
    && act_rate != 32'h0 && now >= next_fire;
  assign next_step = next_fire + {32'h0, period};

  // [R10] past start fires now and resyncs; [R11] future waits
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      next_fire <= 64'h0;
    end else if (st != pss_pkg::TRG_RUN || !sched_sel) begin
      next_fire <= act_start;
    end else if (fire) begin
      if (next_step <= now) begin
        next_fire <= now + {32'h0, period};
      end else begin
        next_fire <= next_step;
      end
    end
  end

  // [R18] trigger dropped while a frame is in progress
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      TRIG_OUT <= 1'b0;
      drop_cnt <= 16'h0000;
    end else begin
      TRIG_OUT <= fire && !FRAME_BUSY_IN;
      if (fire && FRAME_BUSY_IN && drop_cnt != 16'hFFFF) begin
        drop_cnt <= drop_cnt + 16'h0001;
      end
    end
  end

  // [R1] [R2] [R3] read port, one cycle latency, zero otherwise
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN || !REG_RD_IN) begin
      REG_RDATA_OUT <= 32'h0;
    end else begin
      case (REG_ADDR_IN)
        pss_pkg::A_CTRL: REG_RDATA_OUT <= ctrl;
        pss_pkg::A_OFFSET: REG_RDATA_OUT <= snap.offset;
        pss_pkg::A_OWN_LO: REG_RDATA_OUT <= snap.own_id[31:0];
        pss_pkg::A_OWN_HI: REG_RDATA_OUT <= snap.own_id[63:32];
        pss_pkg::A_MST_LO: REG_RDATA_OUT <= snap.master_id[31:0];
        pss_pkg::A_MST_HI: REG_RDATA_OUT <= snap.master_id[63:32];
        pss_pkg::A_STATE_SNAP: REG_RDATA_OUT <= {28'h0, snap.state};
        pss_pkg::A_STATE_LIVE: REG_RDATA_OUT <= {28'h0, live};
        pss_pkg::A_TS_LO: REG_RDATA_OUT <= ts_snap[31:0];
        pss_pkg::A_TS_HI: REG_RDATA_OUT <= ts_snap[63:32];
        pss_pkg::A_START_LO: REG_RDATA_OUT <= start_lo;
        pss_pkg::A_START_HI: REG_RDATA_OUT <= start_hi;
        pss_pkg::A_RATE: REG_RDATA_OUT <= rate;
        pss_pkg::A_STATUS: REG_RDATA_OUT <= {drop_cnt, 14'h0, st};
        default: REG_RDATA_OUT <= 32'h0;
      endcase
    end
  end

  assign TIME_SYNC_ENABLE_OUT = sync_en;
  assign LIVE_STATE_OUT = live;
  assign LOCAL_TIME_OUT = now;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  a_snap_capture: assert property ( // [R5]
    cmd_snap |=> snap.offset == $past(OFFSET_IN)
      && snap.master_id == $past(PARENT_ID_IN)
      && snap.own_id == OWN_CLOCK_ID)
    else $error("snapshot did not capture inputs");
  a_snap_frozen: assert property ( // [R6]
    !cmd_snap ##1 !cmd_snap |=> $stable(snap))
    else $error("snapshot changed without command");
  a_live_hold: assert property ( // [R7]
    ref_cnt != 8'h00 |=> $stable(live))
    else $error("live state changed between refreshes");
  a_live_off: assert property ( // [R17]
    !sync_en && ref_cnt == 8'h00 |=> live == pss_pkg::PS_DISABLED)
    else $error("live state not disabled while sync off");
  a_upd_apply: assert property ( // [R14]
    cmd_upd |=> act_start == {$past(start_hi), $past(start_lo)}
      && act_rate == $past(rate))
    else $error("update did not apply pending values");
  a_upd_hold: assert property ( // [R14]
    !cmd_upd |=> $stable(act_rate) && $stable(act_start))
    else $error("active values changed without update");
  a_src_gate: assert property ( // [R15]
    !sched_sel |=> !TRIG_OUT)
    else $error("trigger while timer not selected");
  a_busy_drop: assert property ( // [R18]
    FRAME_BUSY_IN && fire |=> !TRIG_OUT ##0 drop_cnt != 16'h0000)
    else $error("trigger issued during busy frame");
  a_future_wait: assert property ( // [R11]
    st == pss_pkg::TRG_RUN && now < next_fire |=> !TRIG_OUT)
    else $error("trigger before start time");
  a_period_load: assert property ( // [R19]
    cmd_upd ##1 (!cmd_upd)[*8] |-> ##[1:40]
      st == pss_pkg::TRG_RUN)
    else $error("period not ready in time");
  a_ts_latch: assert property ( // [R12]
    cmd_ts |=> ts_snap == $past(now))
    else $error("time stamp not latched");

  c_snapshot: cover property (cmd_snap);
  c_run: cover property (cmd_upd ##[1:40] st == pss_pkg::TRG_RUN);
  c_trigger: cover property (TRIG_OUT ##[1:100] TRIG_OUT);
  c_drop: cover property (fire && FRAME_BUSY_IN);
endmodule

// ### pss_top_bench.sv
// pss_top_bench: self-checking bench for the ptp status block
// assumes: engine model at the far side, registers on the strobe port
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module pss_top_bench;
  localparam logic [63:0] OWN_ID = 64'h0000_00A5_0000_005A; // arbitrary
  localparam logic [63:0] MST_ID = 64'h0000_0011_0000_0022; // arbitrary
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
  } pss_row_s;
  pss_row_s rows[8] = '{
    '{pss_pkg::A_CTRL, 0, 0, 0}, '{pss_pkg::A_RATE, 0, 0, 0},
    '{pss_pkg::A_START_HI, 0, 0, 0}, '{pss_pkg::A_STATE_LIVE, 0, 0, 3},
    '{pss_pkg::A_CMD, 1, 0, 0}, '{8'h3C, 1, 32'hFFFF_FFFF, 0},
    '{pss_pkg::A_START_LO, 1, 32'h1234_5678, 32'h1234_5678},
    '{pss_pkg::A_START_HI, 1, 32'h0000_0005, 32'h0000_0005}};
  logic clk = 0, rst = 1, wr = 0, rd = 0, busy = 0, step_req = 0;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, off = 32'h0000_0123, r, offset, fadj, stepns;
  logic [3:0] cmd_state = 4'h9, pstate, live;
  logic [63:0] parent, now, t_wr, t0;
  logic stepv, sync_en, trig;
  int mismatches = 0, n_compared = 0, cyc = 0, n;
  pss_top #(.OWN_CLOCK_ID(OWN_ID)) i_dut (.CLK_SYS_IN(clk), .RST_IN(rst),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(r), .OFFSET_IN(offset),
    .PARENT_ID_IN(parent), .PORT_STATE_IN(pstate), .FREQ_ADJ_IN(fadj),
    .STEP_VALID_IN(stepv), .STEP_NS_IN(stepns), .FRAME_BUSY_IN(busy),
    .TIME_SYNC_ENABLE_OUT(sync_en), .LIVE_STATE_OUT(live),
    .LOCAL_TIME_OUT(now), .TRIG_OUT(trig));
  pss_engine_model #(.MASTER_ID(MST_ID)) i_eng (.clk_in(clk),
    .rst_in(rst), .sync_on_in(sync_en), .state_in(cmd_state),
    .offset_in(off), .step_req_in(step_req), .offset_out(offset),
    .parent_id_out(parent), .port_state_out(pstate),
    .freq_adj_out(fadj), .step_valid_out(stepv), .step_ns_out(stepns));
  always #12.5 clk = ~clk;
  // whole run needs about 700 cycles, so this only cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task conclude;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // time seen in the cycle the write is taken, for the latch check
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    #1 t_wr = now;
    @(posedge clk);
    wr <= 0;
  endtask
  task rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 d = r;
  endtask
  task wait_trig(input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (trig !== 1'b1 && k < lim);
  endtask
  task chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rreg(a, v);
    `CHK(nm, e, v);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1 `CHK("sync_en", 1'b0, sync_en);
    foreach (rows[i]) begin
      if (rows[i].w) wreg(rows[i].a, rows[i].d);
      chk_reg("reg", rows[i].a, rows[i].e);
    end
    $display("test registers done");
    wreg(pss_pkg::A_START_LO, 0);
    wreg(pss_pkg::A_START_HI, 0);
    wreg(pss_pkg::A_RATE, 32'h000F_4240);
    wreg(pss_pkg::A_CTRL, 32'h0000_0002);
    wreg(pss_pkg::A_CMD, 32'h0000_0004);
    wait_trig(60, n);
    `CHK("first_trig", 1'b1, trig);
    wait_trig(100, n);
    `CHK("period", 40, n);
    chk_reg("timer", pss_pkg::A_STATUS, 32'h0000_0002);
    wreg(pss_pkg::A_RATE, 32'h001E_8480);
    wait_trig(100, n);
    wait_trig(100, n);
    `CHK("held", 40, n);
    wreg(pss_pkg::A_CMD, 32'h0000_0004);
    wait_trig(100, n);
    wait_trig(100, n);
    `CHK("applied", 20, n);
    $display("test trigger rate done");
    @(posedge clk);
    busy <= 1;
    wait_trig(60, n);
    `CHK("dropped_trig", 1'b0, trig);
    rreg(pss_pkg::A_STATUS, t0[31:0]);
    `CHK("drop_cnt", 1'b1, t0[31:16] != 16'h0);
    @(posedge clk);
    busy <= 0;
    wreg(pss_pkg::A_CTRL, 0);
    wait_trig(60, n);
    `CHK("no_source", 1'b0, trig);
    t0 = now + 64'd3000;
    wreg(pss_pkg::A_START_LO, t0[31:0]);
    wreg(pss_pkg::A_CMD, 32'h0000_0004);
    wreg(pss_pkg::A_CTRL, 32'h0000_0002);
    wait_trig(200, n);
    `CHK("future", 1'b1, now >= t0 + 25 && now < t0 + 50);
    $display("test trigger start done");
    wreg(pss_pkg::A_CMD, 32'h0000_0002);
    t0 = t_wr;
    chk_reg("ts_lo", pss_pkg::A_TS_LO, t0[31:0]);
    @(posedge clk);
    #1 `CHK("rdata_idle", 32'h0, r);
    chk_reg("ts_hi", pss_pkg::A_TS_HI, t0[63:32]);
    wreg(pss_pkg::A_CMD, 32'h0000_0001);
    off <= 32'h0000_0456;
    chk_reg("snap_state", pss_pkg::A_STATE_SNAP, 3);
    chk_reg("frozen", pss_pkg::A_OFFSET, 32'h0000_0123);
    chk_reg("own_lo", pss_pkg::A_OWN_LO, OWN_ID[31:0]);
    chk_reg("own_hi", pss_pkg::A_OWN_HI, OWN_ID[63:32]);
    $display("test snapshot done");
    wreg(pss_pkg::A_CTRL, 32'h0000_0001);
    for (int s = 1; s <= 9; s++) begin
      cmd_state <= 4'(s);
      repeat (3) @(posedge clk);
      wreg(pss_pkg::A_CMD, 32'h0000_0001);
      chk_reg("state", pss_pkg::A_STATE_SNAP, 32'(s));
    end
    repeat (45) @(posedge clk);
    #1 `CHK("live", 4'h9, live);
    t0 = now;
    repeat (8) @(posedge clk);
    #1 `CHK("trim", t0 + 64'd202, now);
    @(posedge clk);
    step_req <= 1;
    #1 t0 = now;
    repeat (8) @(posedge clk);
    #1 `CHK("step", t0 + 64'd1202, now);
    wreg(pss_pkg::A_CMD, 32'h0000_0001);
    chk_reg("offset", pss_pkg::A_OFFSET, 32'h0000_0456);
    chk_reg("mst_lo", pss_pkg::A_MST_LO, MST_ID[31:0]);
    chk_reg("mst_hi", pss_pkg::A_MST_HI, MST_ID[63:32]);
    // software sees slave role latched before it would start frames
    chk_reg("settled", pss_pkg::A_STATE_SNAP, 32'h0000_0009);
    $display("test sync done");
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    chk_reg("ctrl_rst", pss_pkg::A_CTRL, 0);
    `CHK("sync_off", 1'b0, sync_en);
    $display("test restart done");
    conclude();
  end
endmodule
